// file: design/drvpl_pkg.sv
// constants and types for drive profile, write lock and source selection
package drvpl_pkg;
  localparam int NUM_TERMS = 8;
  localparam int ROLE_W = 8;
  localparam int SRC_W = 2;
  localparam int NUM_SRCS = 4;
  localparam int BANK_W = 2;

  // terminal role codes (decimal 08, 17, 15, 31, 51)
  localparam logic [ROLE_W-1:0] ROLE_PROFILE2 = 8'h08;
  localparam logic [ROLE_W-1:0] ROLE_PROFILE3 = 8'h11;
  localparam logic [ROLE_W-1:0] ROLE_WRITE_LOCK = 8'h0f;
  localparam logic [ROLE_W-1:0] ROLE_PANEL_FORCE = 8'h1f;
  localparam logic [ROLE_W-1:0] ROLE_TERM_FORCE = 8'h33;

  // lock modes (decimal 00, 01, 02, 03, 10)
  localparam logic [ROLE_W-1:0] LOCK_INPUT_ALL = 8'h00;
  localparam logic [ROLE_W-1:0] LOCK_INPUT_FREQ = 8'h01;
  localparam logic [ROLE_W-1:0] LOCK_ALWAYS_ALL = 8'h02;
  localparam logic [ROLE_W-1:0] LOCK_ALWAYS_FREQ = 8'h03;
  localparam logic [ROLE_W-1:0] LOCK_RUN_CHANGE = 8'h0a;

  // command source codes
  localparam logic [SRC_W-1:0] SRC_TERMINAL = 2'h1;
  localparam logic [SRC_W-1:0] SRC_PANEL = 2'h2;
  localparam logic [SRC_W-1:0] SRC_RESET = 2'h1;

  // parameter copy index driven to the parameter store
  localparam logic [BANK_W-1:0] BANK_FIRST = 2'h0;
  localparam logic [BANK_W-1:0] BANK_SECOND = 2'h1;
  localparam logic [BANK_W-1:0] BANK_THIRD = 2'h2;

  typedef enum logic [2:0] {
    PROF_FIRST = 3'b001,
    PROF_SECOND = 3'b010,
    PROF_THIRD = 3'b100
  } drvpl_prof_t;
endpackage

// file: design/drvpl_top.sv
// profile select, parameter write lock and command source forcing
// Functional notes
// - terminal with role code 08 selects the second motor profile
// - terminal with role code 17 selects the third motor profile
// - both select inputs on: second profile wins
// - active profile never changes while the motor runs
// - active profile steers parameter copy; some items lack a third copy
// - no output tells which profile is active
// - terminal with role code 15 is the write lock input
// - mode 00: lock input on rejects all writes but lock mode
// - mode 01: lock input on allows only lock mode and frequency items
// - mode 02: always reject writes except lock mode
// - mode 03: always allow only lock mode and frequency items
// - mode 10: only lock mode and items changeable during operation may be written
// - role code 31 input on forces both sources to panel keypad
// - no force input on: sources follow frequency and run choices
// - source change while operating cancels run command, stops output
// - terminal force lets terminal block operate when not selected
// - role code 51 input on forces both sources to terminal block unless role code 31 input is on
module drvpl_top
  import drvpl_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // input terminals and their role codes
  input wire logic [NUM_TERMS-1:0] term_pin,
  input wire logic [ROLE_W-1:0] terminal_role_codes [NUM_TERMS],
  // motor state
  input wire logic motor_running,
  input wire logic item_has_copy3,
  output logic [BANK_W-1:0] param_bank_r,
  // parameter write request
  input wire logic [ROLE_W-1:0] lock_mode_choice,
  input wire logic wr_req,
  input wire logic wr_is_lock_mode,
  input wire logic wr_is_freq_item,
  input wire logic wr_run_changeable,
  output logic wr_accept_r,
  output logic wr_reject_r,
  // command sources
  input wire logic [SRC_W-1:0] freq_source_choice,
  input wire logic [SRC_W-1:0] run_source_choice,
  input wire logic [NUM_SRCS-1:0] run_cmd_by_src,
  output logic [SRC_W-1:0] freq_src_r,
  output logic [SRC_W-1:0] run_src_r,
  output logic run_enable_r,
  output logic run_cancel_r
);

  function automatic logic role_hit(
    input logic [ROLE_W-1:0] codes [NUM_TERMS],
    input logic [NUM_TERMS-1:0] lvl,
    input logic [ROLE_W-1:0] code
  );
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERMS; i++) begin
      if (codes[i] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  function automatic logic write_ok(
    input logic [ROLE_W-1:0] mode,
    input logic lock_in,
    input logic is_lock,
    input logic is_freq,
    input logic is_runchg
  );
    logic ok;
    ok = 1'b1;
    if (!is_lock) begin
      unique case (mode)
        LOCK_INPUT_ALL: ok = !lock_in;
        LOCK_INPUT_FREQ: ok = !lock_in || is_freq;
        LOCK_ALWAYS_ALL: ok = 1'b0;
        LOCK_ALWAYS_FREQ: ok = is_freq;
        LOCK_RUN_CHANGE: ok = is_runchg;
        default: ok = 1'b1;
      endcase
    end
    return ok;
  endfunction

  function automatic logic [BANK_W-1:0] bank_of(
    input drvpl_prof_t prof,
    input logic has3
  );
    logic [BANK_W-1:0] b;
    b = BANK_FIRST;
    unique case (prof)
      PROF_FIRST: b = BANK_FIRST;
      PROF_SECOND: b = BANK_SECOND;
      PROF_THIRD: b = has3 ? BANK_THIRD : BANK_FIRST;
      default: b = BANK_FIRST;
    endcase
    return b;
  endfunction

  // three-stage terminal synchroniser, change taken when stages 2 and 3 agree
  logic [NUM_TERMS-1:0] term_s1_r;
  logic [NUM_TERMS-1:0] term_s2_r;
  logic [NUM_TERMS-1:0] term_s3_r;
  logic [NUM_TERMS-1:0] term_flt_r;
  logic [NUM_TERMS-1:0] term_agree;
  assign term_agree = ~(term_s2_r ^ term_s3_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      term_s1_r <= '0;
      term_s2_r <= '0;
      term_s3_r <= '0;
      term_flt_r <= '0;
    end else begin
      term_s1_r <= term_pin;
      term_s2_r <= term_s1_r;
      term_s3_r <= term_s2_r;
      term_flt_r <= (term_s2_r & term_agree) | (term_flt_r & ~term_agree);
    end
  end

  // terminal role decode
  logic prof2_in;
  logic prof3_in;
  logic write_lock_input;
  logic panel_force_input;
  logic terminal_force_input;
  always_comb begin
    prof2_in = role_hit(terminal_role_codes, term_flt_r,
                        ROLE_PROFILE2);
    prof3_in = role_hit(terminal_role_codes, term_flt_r,
                        ROLE_PROFILE3);
    write_lock_input = role_hit(terminal_role_codes, term_flt_r,
                                ROLE_WRITE_LOCK);
    panel_force_input = role_hit(terminal_role_codes, term_flt_r,
                                 ROLE_PANEL_FORCE);
    terminal_force_input = role_hit(terminal_role_codes, term_flt_r,
                                    ROLE_TERM_FORCE);
  end

  // profile selection, latched only at standstill
  drvpl_prof_t prof_sel;
  drvpl_prof_t active_prof_r;
  always_comb begin
    if (prof2_in) begin
      prof_sel = PROF_SECOND;
    end else if (prof3_in) begin
      prof_sel = PROF_THIRD;
    end else begin
      prof_sel = PROF_FIRST;
    end
  end

  // pending selection is simply prof_sel, sampled once running drops
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_prof_r <= PROF_FIRST;
    end else if (!motor_running) begin
      active_prof_r <= prof_sel;
    end
  end

  // bank index only steers the store, no profile indicator is driven
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      param_bank_r <= BANK_FIRST;
    end else begin
      param_bank_r <= bank_of(active_prof_r, item_has_copy3);
    end
  end

  // write lock check, answer one cycle after the request
  logic wr_ok;
  assign wr_ok = write_ok(lock_mode_choice, write_lock_input,
                          wr_is_lock_mode, wr_is_freq_item,
                          wr_run_changeable);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_accept_r <= 1'b0;
      wr_reject_r <= 1'b0;
    end else begin
      wr_accept_r <= wr_req && wr_ok;
      wr_reject_r <= wr_req && !wr_ok;
    end
  end

  // command source selection
  logic [SRC_W-1:0] freq_src_nxt;
  logic [SRC_W-1:0] run_src_nxt;
  logic src_change;
  logic cancel_nxt;
  always_comb begin
    if (panel_force_input) begin
      freq_src_nxt = SRC_PANEL;
      run_src_nxt = SRC_PANEL;
    end else if (terminal_force_input) begin
      freq_src_nxt = SRC_TERMINAL;
      run_src_nxt = SRC_TERMINAL;
    end else begin
      freq_src_nxt = freq_source_choice;
      run_src_nxt = run_source_choice;
    end
  end

  assign src_change = (freq_src_nxt != freq_src_r) ||
                      (run_src_nxt != run_src_r);
  // cancel held until every source releases its run command; set wins
  always_comb begin
    cancel_nxt = run_cancel_r;
    if (run_cancel_r && run_cmd_by_src == '0) begin
      cancel_nxt = 1'b0;
    end
    if (src_change && (motor_running || run_enable_r)) begin
      cancel_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      freq_src_r <= SRC_RESET;
      run_src_r <= SRC_RESET;
    end else begin
      freq_src_r <= freq_src_nxt;
      run_src_r <= run_src_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_cancel_r <= 1'b0;
      run_enable_r <= 1'b0;
    end else begin
      run_cancel_r <= cancel_nxt;
      run_enable_r <= run_cmd_by_src[run_src_nxt] && !cancel_nxt;
    end
  end

  // checks
  property p_prof_hold;
    @(posedge mclk) disable iff (!rst_n)
    motor_running |=> active_prof_r == $past(active_prof_r);
  endproperty
  a_prof_hold: assert property (p_prof_hold)
    else $error("profile changed while running");

  property p_prof_apply;
    @(posedge mclk) disable iff (!rst_n)
    !motor_running |=> active_prof_r == $past(prof_sel);
  endproperty
  a_prof_apply: assert property (p_prof_apply)
    else $error("pending profile not applied at standstill");

  property p_prof_prio;
    @(posedge mclk) disable iff (!rst_n)
    prof2_in && prof3_in && !motor_running |=> active_prof_r == PROF_SECOND;
  endproperty
  a_prof_prio: assert property (p_prof_prio)
    else $error("second profile lost priority");

  property p_prof_default;
    @(posedge mclk) disable iff (!rst_n)
    !prof2_in && !prof3_in && !motor_running ##1 !motor_running
      |=> param_bank_r == BANK_FIRST;
  endproperty
  a_prof_default: assert property (p_prof_default)
    else $error("first profile not used");

  property p_lock_item;
    @(posedge mclk) disable iff (!rst_n)
    wr_req && wr_is_lock_mode |=> wr_accept_r && !wr_reject_r;
  endproperty
  a_lock_item: assert property (p_lock_item)
    else $error("lock mode write rejected");

  property p_mode0_open;
    @(posedge mclk) disable iff (!rst_n)
    wr_req && lock_mode_choice == LOCK_INPUT_ALL && !write_lock_input
      |=> wr_accept_r;
  endproperty
  a_mode0_open: assert property (p_mode0_open)
    else $error("mode 00 rejected with lock input off");

  property p_mode1_lock;
    @(posedge mclk) disable iff (!rst_n)
    wr_req && lock_mode_choice == LOCK_INPUT_FREQ && write_lock_input &&
      !wr_is_lock_mode && !wr_is_freq_item |=> wr_reject_r;
  endproperty
  a_mode1_lock: assert property (p_mode1_lock)
    else $error("mode 01 accepted locked item");

  property p_mode2;
    @(posedge mclk) disable iff (!rst_n)
    wr_req && lock_mode_choice == LOCK_ALWAYS_ALL && !wr_is_lock_mode
      |=> wr_reject_r;
  endproperty
  a_mode2: assert property (p_mode2)
    else $error("mode 02 accepted a write");

  property p_mode3;
    @(posedge mclk) disable iff (!rst_n)
    wr_req && lock_mode_choice == LOCK_ALWAYS_FREQ
      |=> wr_accept_r == $past(wr_is_freq_item || wr_is_lock_mode);
  endproperty
  a_mode3: assert property (p_mode3)
    else $error("mode 03 decision wrong");

  property p_mode10;
    @(posedge mclk) disable iff (!rst_n)
    wr_req && lock_mode_choice == LOCK_RUN_CHANGE && !wr_is_lock_mode
      |=> wr_reject_r == $past(!wr_run_changeable);
  endproperty
  a_mode10: assert property (p_mode10)
    else $error("mode 10 decision wrong");

  property p_panel;
    @(posedge mclk) disable iff (!rst_n)
    panel_force_input |=> freq_src_r == SRC_PANEL && run_src_r == SRC_PANEL;
  endproperty
  a_panel: assert property (p_panel)
    else $error("panel force not applied");

  property p_terminal;
    @(posedge mclk) disable iff (!rst_n)
    terminal_force_input && !panel_force_input
      |=> freq_src_r == SRC_TERMINAL && run_src_r == SRC_TERMINAL;
  endproperty
  a_terminal: assert property (p_terminal)
    else $error("terminal force not applied");

  property p_choice;
    @(posedge mclk) disable iff (!rst_n)
    !terminal_force_input && !panel_force_input
      |=> freq_src_r == $past(freq_source_choice) &&
          run_src_r == $past(run_source_choice);
  endproperty
  a_choice: assert property (p_choice)
    else $error("source choice not followed");

  property p_cancel;
    @(posedge mclk) disable iff (!rst_n)
    src_change && motor_running |=> run_cancel_r && !run_enable_r;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("source change did not cancel run");

  property p_cancel_gate;
    @(posedge mclk) disable iff (!rst_n)
    run_cancel_r |-> !run_enable_r;
  endproperty
  a_cancel_gate: assert property (p_cancel_gate)
    else $error("run enabled while cancelled");

  c_pending: cover property (@(posedge mclk) disable iff (!rst_n)
    motor_running && prof_sel != active_prof_r ##1 !motor_running
      ##1 active_prof_r == $past(prof_sel));
  c_cancel: cover property (@(posedge mclk) disable iff (!rst_n)
    run_cancel_r ##1 !run_cancel_r ##[1:20] run_enable_r);
  c_reject: cover property (@(posedge mclk) disable iff (!rst_n)
    wr_reject_r);
  c_third: cover property (@(posedge mclk) disable iff (!rst_n)
    param_bank_r == BANK_THIRD);
endmodule

// file: sim/drvpl_far_model.sv
// far-side model: terminal contacts and per-source run commands
module drvpl_far_model
  import drvpl_pkg::*;
(
  // clock
  input wire logic mclk,
  // levels ordered by the bench
  input wire logic [NUM_TERMS-1:0] term_lvl,
  input wire logic [NUM_SRCS-1:0] run_req,
  // lines toward the drive
  output logic [NUM_TERMS-1:0] term_pin,
  output logic [NUM_SRCS-1:0] run_cmd_by_src
);
  timeunit 1ns;
  timeprecision 1ps;

  // contacts settle one cycle after being ordered
  always_ff @(posedge mclk) begin
    term_pin <= term_lvl;
  end

  // commands released and reissued only when ordered
  always_ff @(posedge mclk) begin
    run_cmd_by_src <= run_req;
  end
endmodule

// file: sim/drvpl_top_test.sv
// self-checking bench for profile select, write lock and source forcing
module drvpl_top_test
  import drvpl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst_n, motor_running, item_has_copy3;
  logic [NUM_TERMS-1:0] term_lvl, term_pin;
  logic [NUM_SRCS-1:0] run_req, run_cmd_by_src;
  logic [ROLE_W-1:0] roles [NUM_TERMS];
  logic [ROLE_W-1:0] lock_mode_choice;
  logic wr_req, wr_is_lock_mode, wr_is_freq_item, wr_run_changeable;
  logic wr_accept_r, wr_reject_r, run_enable_r, run_cancel_r;
  logic [BANK_W-1:0] param_bank_r;
  logic [SRC_W-1:0] freq_source_choice, run_source_choice;
  logic [SRC_W-1:0] freq_src_r, run_src_r;
  int n_mismatch, check_count, seed, act;
  logic [ROLE_W-1:0] modes [6];

  drvpl_far_model u_drvpl_far_model (.mclk(mclk), .term_lvl(term_lvl),
    .run_req(run_req), .term_pin(term_pin),
    .run_cmd_by_src(run_cmd_by_src));

  drvpl_top u_drvpl_top (.mclk(mclk), .rst_n(rst_n), .term_pin(term_pin),
    .terminal_role_codes(roles), .motor_running(motor_running),
    .item_has_copy3(item_has_copy3), .param_bank_r(param_bank_r),
    .lock_mode_choice(lock_mode_choice), .wr_req(wr_req),
    .wr_is_lock_mode(wr_is_lock_mode), .wr_is_freq_item(wr_is_freq_item),
    .wr_run_changeable(wr_run_changeable), .wr_accept_r(wr_accept_r),
    .wr_reject_r(wr_reject_r), .freq_source_choice(freq_source_choice),
    .run_source_choice(run_source_choice), .run_cmd_by_src(run_cmd_by_src),
    .freq_src_r(freq_src_r), .run_src_r(run_src_r),
    .run_enable_r(run_enable_r), .run_cancel_r(run_cancel_r));

  always #5 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ends on an edge: drives land on it, reads see the prior edge's outputs
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // reference decision for a write request
  function automatic bit lock_ok(input logic [7:0] m, input bit lk,
                                 input bit il, input bit fq, input bit rc);
    if (il) return 1'b1;
    if (m == LOCK_INPUT_ALL) return !lk;
    if (m == LOCK_INPUT_FREQ) return !lk || fq;
    if (m == LOCK_ALWAYS_ALL) return 1'b0;
    if (m == LOCK_ALWAYS_FREQ) return fq;
    if (m == LOCK_RUN_CHANGE) return rc;
    return 1'b1;
  endfunction

  function automatic logic [1:0] bank_of(input int a, input bit c3);
    if (a == 2) return BANK_SECOND;
    if (a == 3 && c3) return BANK_THIRD;
    return BANK_FIRST;
  endfunction

  task automatic do_write(input logic [7:0] m, input bit lk);
    bit il, fq, rc, ok;
    il = 1'($random(seed));
    fq = 1'($random(seed));
    rc = 1'($random(seed));
    @(posedge mclk);
    wr_req <= 1'b1;
    wr_is_lock_mode <= il;
    wr_is_freq_item <= fq;
    wr_run_changeable <= rc;
    @(posedge mclk);
    wr_req <= 1'b0;
    @(posedge mclk);
    ok = lock_ok(m, lk, il, fq, rc);
    check({6'h0, wr_accept_r, wr_reject_r}, {6'h0, ok, !ok});
  endtask

  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    logic [1:0] exp_src;
    seed = 28600;
    mclk = 1'b0;
    rst_n = 1'b0;
    motor_running = 1'b0;
    item_has_copy3 = 1'b0;
    term_lvl = '0;
    run_req = '0;
    lock_mode_choice = LOCK_INPUT_ALL;
    wr_req = 1'b0;
    wr_is_lock_mode = 1'b0;
    wr_is_freq_item = 1'b0;
    wr_run_changeable = 1'b0;
    freq_source_choice = SRC_TERMINAL;
    run_source_choice = SRC_TERMINAL;
    modes = '{LOCK_INPUT_ALL, LOCK_INPUT_FREQ, LOCK_ALWAYS_ALL,
              LOCK_ALWAYS_FREQ, LOCK_RUN_CHANGE, 8'h05};
    roles = '{ROLE_PROFILE2, ROLE_PROFILE3, ROLE_WRITE_LOCK,
              ROLE_PANEL_FORCE, ROLE_TERM_FORCE, 8'h63, 8'h63, 8'h63};
    n_mismatch = 0;
    check_count = 0;
    act = 1;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    settle(4);
    // profile switching, held off while running
    for (int i = 0; i < 16; i++) begin
      motor_running <= 1'b1;
      item_has_copy3 <= i[2];
      term_lvl <= {3'($random(seed)), 3'h0, i[1], i[0]};
      settle(8);
      check({6'h0, param_bank_r}, {6'h0, bank_of(act, i[2])});
      motor_running <= 1'b0;
      settle(5);
      act = i[0] ? 2 : (i[1] ? 3 : 1);
      check({6'h0, param_bank_r}, {6'h0, bank_of(act, i[2])});
    end
    // command source forcing with the motor stopped
    for (int i = 0; i < 12; i++) begin
      freq_source_choice <= 2'($random(seed));
      run_source_choice <= 2'($random(seed));
      term_lvl <= {3'h0, i[1], i[0], 3'h0};
      settle(8);
      exp_src = i[0] ? SRC_PANEL : (i[1] ? SRC_TERMINAL : freq_source_choice);
      check({6'h0, freq_src_r}, {6'h0, exp_src});
      exp_src = i[0] ? SRC_PANEL : (i[1] ? SRC_TERMINAL : run_source_choice);
      check({6'h0, run_src_r}, {6'h0, exp_src});
    end
    // source change while running cancels the run command
    term_lvl <= '0;
    run_source_choice <= SRC_TERMINAL;
    freq_source_choice <= SRC_TERMINAL;
    settle(8);
    run_req <= 4'h2;
    motor_running <= 1'b1;
    settle(4);
    check({7'h0, run_enable_r}, 8'h01);
    term_lvl <= 8'h08;
    settle(8);
    check({6'h0, run_cancel_r, run_enable_r}, 8'h02);
    run_req <= 4'h6;
    settle(4);
    check({7'h0, run_enable_r}, 8'h00);
    run_req <= 4'h0;
    motor_running <= 1'b0;
    settle(4);
    check({6'h0, run_cancel_r, run_enable_r}, 8'h00);
    run_req <= 4'h4;
    settle(4);
    check({6'h0, run_cancel_r, run_enable_r}, 8'h01);
    run_req <= 4'h0;
    term_lvl <= '0;
    settle(8);
    // write lock across every mode and lock input level
    for (int i = 0; i < 48; i++) begin
      lock_mode_choice <= modes[i % 6];
      term_lvl <= {5'h0, 1'($random(seed)), 2'h0};
      settle(6);
      do_write(lock_mode_choice, term_lvl[2]);
    end
    end_sim();
  end
endmodule
